//--- core/tc_reporter_pkg.sv
// Constants, register map and range table for the thermocouple result reporter
package tc_reporter_pkg;
  localparam int NUM_CH = 8;
  localparam logic [3:0] CJC_INDEX = 4'h8;
  // Register byte offsets
  localparam logic [11:0] READING_BASE = 12'h000;
  localparam logic [11:0] READING_LAST = 12'h01C;
  localparam logic [11:0] STATUS_OFS = 12'h020;
  localparam logic [11:0] INT_TEMP_OFS = 12'h024;
  localparam logic [11:0] CONFIG_OFS = 12'h028;
  localparam logic [11:0] RANGE_OFS = 12'h02C;
  localparam logic [11:0] OCD_DIS_OFS = 12'h030;
  localparam logic [11:0] IRQ_STS_OFS = 12'h034;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h038;
  // Configuration fields and reset values
  localparam int CFG_UNIT_F_BIT = 0;
  localparam int CFG_RES_TENTH_BIT = 1;
  localparam logic [1:0] CONFIG_RST = 2'h2;
  localparam logic [31:0] RANGE_RST = 32'h0000_0000;
  localparam logic [7:0] OCD_DIS_RST = 8'h00;
  localparam logic [15:0] IRQ_RST = 16'h0000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam int RANGE_FIELD_W = 4;
  localparam int STATUS_WARN_LSB = 0;
  localparam int STATUS_OOR_LSB = 8;
  // Input range selection per channel
  typedef enum logic [3:0] {
    RANGE_J = 4'b0000,
    RANGE_K = 4'b0001,
    RANGE_E = 4'b0010,
    RANGE_T = 4'b0011,
    RANGE_S = 4'b0100,
    RANGE_R = 4'b0101,
    RANGE_B = 4'b0110,
    RANGE_MV100 = 4'b0111,
    RANGE_MV25 = 4'b1000
  } range_t;
  // Bands in tenths of a degree C, order J K E T S R B
  localparam logic signed [15:0] TC_MIN_READ [0:6] = '{16'hF713, 16'hF42B, 16'hF486, 16'hF515,
                                                       16'hFC7D, 16'hFC80, 16'h0360};
  localparam logic signed [15:0] TC_NORM_MAX [0:6] = '{16'h1DB0, 16'h3584, 16'h2710, 16'h0FA0,
                                                       16'h410A, 16'h410A, 16'h4718};
  localparam logic signed [15:0] TC_WARN_MAX [0:6] = '{16'h1E6A, 16'h36E2, 16'h27FF, 16'h1000,
                                                       16'h429A, 16'h4297, 16'h48CD};
  // Fixed codes
  localparam logic [15:0] SAT_OVER_CODE = 16'h7FFF;
  localparam logic [15:0] SAT_UNDER_CODE = 16'h8001;
  localparam logic [15:0] MV_FULL_CODE = 16'hFFFF;
  localparam logic [15:0] MV_SIGN_FLIP = 16'h8000;
  // Unit conversion
  localparam logic signed [31:0] F_SCALE_NUM = 32'sh0000_0009;
  localparam logic signed [31:0] F_SCALE_DEN = 32'sh0000_0005;
  localparam logic signed [31:0] F_OFFSET_TENTHS = 32'sh0000_0140;
  localparam logic signed [31:0] TENTHS_PER_DEG = 32'sh0000_000A;
  localparam logic signed [31:0] WORD_U_MAX = 32'sh0000_FFFF;
  localparam logic signed [31:0] WORD_S_MAX = 32'sh0000_7FFF;
  localparam logic signed [31:0] WORD_S_MIN = 32'shFFFF_8000;
  localparam logic signed [31:0] WORD_ZERO = 32'sh0000_0000;
endpackage

//--- core/temp_word_encoder.sv
// Temperature word encoder: unit, resolution and signed or unsigned format
`timescale 1ns/1ps
module temp_word_encoder (
  // Temperature in tenths of a degree C
  input wire logic signed [15:0] celsius_tenths,
  // Format selection
  input wire logic unit_fahrenheit,
  input wire logic res_tenth,
  // Encoded word
  output logic [15:0] word
);
  logic signed [31:0] scaled;

  always_comb begin
    scaled = 32'(celsius_tenths);
    if (unit_fahrenheit) begin
      scaled = (scaled * tc_reporter_pkg::F_SCALE_NUM) / tc_reporter_pkg::F_SCALE_DEN
               + tc_reporter_pkg::F_OFFSET_TENTHS;
    end
    if (!res_tenth) begin
      scaled = scaled / tc_reporter_pkg::TENTHS_PER_DEG;
    end
    // Tenth-degree F needs the full unsigned span; every other format stays signed
    if (unit_fahrenheit && res_tenth) begin
      if (scaled < tc_reporter_pkg::WORD_ZERO) begin
        word = 16'h0000;
      end else if (scaled > tc_reporter_pkg::WORD_U_MAX) begin
        word = 16'hFFFF;
      end else begin
        word = scaled[15:0];
      end
    end else if (scaled > tc_reporter_pkg::WORD_S_MAX) begin
      word = tc_reporter_pkg::SAT_OVER_CODE;
    end else if (scaled < tc_reporter_pkg::WORD_S_MIN) begin
      word = tc_reporter_pkg::MV_SIGN_FLIP;
    end else begin
      word = scaled[15:0];
    end
  end
endmodule

//--- core/tc_band_check.sv
// Per-sample band classification for thermocouple and millivolt ranges
`timescale 1ns/1ps
module tc_band_check (
  // Sample
  input wire logic [3:0] range_code,
  input wire logic signed [15:0] value,
  input wire logic open_wire,
  input wire logic ocd_disable,
  // Classification
  output logic is_mv,
  output logic warn,
  output logic oor,
  output logic over,
  output logic under,
  output logic [15:0] mv_word
);
  logic [2:0] tc_idx;

  always_comb begin
    tc_idx = 3'h0;
    is_mv = 1'b0;
    case (range_code)
      tc_reporter_pkg::RANGE_J: tc_idx = 3'h0;
      tc_reporter_pkg::RANGE_K: tc_idx = 3'h1;
      tc_reporter_pkg::RANGE_E: tc_idx = 3'h2;
      tc_reporter_pkg::RANGE_T: tc_idx = 3'h3;
      tc_reporter_pkg::RANGE_S: tc_idx = 3'h4;
      tc_reporter_pkg::RANGE_R: tc_idx = 3'h5;
      tc_reporter_pkg::RANGE_B: tc_idx = 3'h6;
      tc_reporter_pkg::RANGE_MV100: is_mv = 1'b1;
      tc_reporter_pkg::RANGE_MV25: is_mv = 1'b1;
      // Unused codes fall back to the first thermocouple type
      default: tc_idx = 3'h0;
    endcase
  end

  // Offset binary: negative full scale 0, zero 8000h, positive full scale FFFFh
  assign mv_word = value ^ tc_reporter_pkg::MV_SIGN_FLIP;

  always_comb begin
    over = !is_mv && (value > tc_reporter_pkg::TC_WARN_MAX[tc_idx]);
    under = !is_mv && (value < tc_reporter_pkg::TC_MIN_READ[tc_idx]);
    if (is_mv) begin
      warn = 1'b0;
      oor = !ocd_disable && (open_wire || mv_word == tc_reporter_pkg::MV_FULL_CODE);
    end else begin
      // Open detection cannot be switched off for thermocouples
      oor = over || under || open_wire;
      warn = !oor && (value > tc_reporter_pkg::TC_NORM_MAX[tc_idx]);
    end
  end
endmodule

//--- core/tc_result_reporter.sv
// Thermocouple input result reporter with APB register access and interrupt
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
module tc_result_reporter (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurement samples, channel 8 carries the cold junction temperature
  input wire logic sample_valid,
  input wire logic [3:0] sample_channel,
  input wire logic [15:0] sample_value,
  input wire logic sample_open,
  // Interrupt
  output logic irq
);
  logic [15:0] reading_ff [0:tc_reporter_pkg::NUM_CH-1];
  logic [15:0] int_temp_ff;
  logic [7:0] warn_ff;
  logic [7:0] oor_ff;
  logic [1:0] config_ff;
  logic [31:0] range_ff;
  logic [7:0] ocd_dis_ff;
  logic [15:0] irq_sts_ff;
  logic [15:0] irq_mask_ff;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic [15:0] nxt_word;
  logic [15:0] irq_set;
  logic [15:0] irq_clr;
  logic [2:0] chan_idx;
  logic [3:0] chan_range;
  logic is_chan;
  logic is_cjc;
  logic band_mv;
  logic band_warn;
  logic band_oor;
  logic band_over;
  logic band_under;
  logic [15:0] mv_word;
  logic [15:0] enc_word;
  logic wr_en;
  logic rd_setup;
  logic addr_mapped;
  logic reading_hit;

  assign chan_idx = sample_channel[2:0];
  assign is_chan = sample_channel < tc_reporter_pkg::CJC_INDEX;
  assign is_cjc = sample_channel == tc_reporter_pkg::CJC_INDEX;
  assign chan_range = range_ff[{chan_idx, 2'b00} +: tc_reporter_pkg::RANGE_FIELD_W];

  tc_band_check u_band (
    .range_code(chan_range),
    .value(sample_value),
    .open_wire(sample_open),
    .ocd_disable(ocd_dis_ff[chan_idx]),
    .is_mv(band_mv),
    .warn(band_warn),
    .oor(band_oor),
    .over(band_over),
    .under(band_under),
    .mv_word(mv_word)
  );

  // One encoder serves channels and the cold junction; samples arrive one per cycle
  temp_word_encoder u_enc (
    .celsius_tenths(sample_value),
    .unit_fahrenheit(config_ff[tc_reporter_pkg::CFG_UNIT_F_BIT]),
    .res_tenth(config_ff[tc_reporter_pkg::CFG_RES_TENTH_BIT]),
    .word(enc_word)
  );

  // Data word selection; an open thermocouple reads as upscale
  always_comb begin
    if (band_mv) begin
      nxt_word = mv_word;
    end else if (band_over || sample_open) begin
      nxt_word = tc_reporter_pkg::SAT_OVER_CODE;
    end else if (band_under) begin
      nxt_word = tc_reporter_pkg::SAT_UNDER_CODE;
    end else begin
      nxt_word = enc_word;
    end
  end

  // Channel readings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < tc_reporter_pkg::NUM_CH; i++) begin
        reading_ff[i] <= tc_reporter_pkg::WORD_RST;
      end
    end else if (sample_valid && is_chan) begin
      reading_ff[chan_idx] <= nxt_word;
    end
  end

  // Internal temperature word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_temp_ff <= tc_reporter_pkg::WORD_RST;
    end else if (sample_valid && is_cjc) begin
      int_temp_ff <= enc_word;
    end
  end

  // Channel status bits follow the latest sample of each channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_ff <= 8'h00;
      oor_ff <= 8'h00;
    end else if (sample_valid && is_chan) begin
      warn_ff[chan_idx] <= band_warn && !band_oor;
      oor_ff[chan_idx] <= band_oor;
    end
  end

  // Bus decode; zero wait states so the access phase always completes at once
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign reading_hit = (paddr <= tc_reporter_pkg::READING_LAST) && (paddr[1:0] == 2'b00);

  always_comb begin
    addr_mapped = reading_hit;
    case (paddr)
      tc_reporter_pkg::STATUS_OFS: addr_mapped = 1'b1;
      tc_reporter_pkg::INT_TEMP_OFS: addr_mapped = 1'b1;
      tc_reporter_pkg::CONFIG_OFS: addr_mapped = 1'b1;
      tc_reporter_pkg::RANGE_OFS: addr_mapped = 1'b1;
      tc_reporter_pkg::OCD_DIS_OFS: addr_mapped = 1'b1;
      tc_reporter_pkg::IRQ_STS_OFS: addr_mapped = 1'b1;
      tc_reporter_pkg::IRQ_MASK_OFS: addr_mapped = 1'b1;
      default: addr_mapped = reading_hit;
    endcase
  end

  assign pslverr = psel && penable && !addr_mapped;

  // Read data is prepared in the setup cycle and held for the access cycle
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (reading_hit) begin
      nxt_prdata = {16'h0000, reading_ff[paddr[4:2]]};
    end else begin
      case (paddr)
        tc_reporter_pkg::STATUS_OFS: nxt_prdata = {16'h0000, oor_ff, warn_ff};
        tc_reporter_pkg::INT_TEMP_OFS: nxt_prdata = {16'h0000, int_temp_ff};
        tc_reporter_pkg::CONFIG_OFS: nxt_prdata = {30'h0000_0000, config_ff};
        tc_reporter_pkg::RANGE_OFS: nxt_prdata = range_ff;
        tc_reporter_pkg::OCD_DIS_OFS: nxt_prdata = {24'h00_0000, ocd_dis_ff};
        tc_reporter_pkg::IRQ_STS_OFS: nxt_prdata = {16'h0000, irq_sts_ff};
        tc_reporter_pkg::IRQ_MASK_OFS: nxt_prdata = {16'h0000, irq_mask_ff};
        default: nxt_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata = prdata_ff;

  // Writable configuration; reading words are read-only and ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_ff <= tc_reporter_pkg::CONFIG_RST;
      range_ff <= tc_reporter_pkg::RANGE_RST;
      ocd_dis_ff <= tc_reporter_pkg::OCD_DIS_RST;
      irq_mask_ff <= tc_reporter_pkg::IRQ_RST;
    end else if (wr_en) begin
      case (paddr)
        tc_reporter_pkg::CONFIG_OFS: config_ff <= pwdata[1:0];
        tc_reporter_pkg::RANGE_OFS: range_ff <= pwdata;
        tc_reporter_pkg::OCD_DIS_OFS: ocd_dis_ff <= pwdata[7:0];
        tc_reporter_pkg::IRQ_MASK_OFS: irq_mask_ff <= pwdata[15:0];
        default: config_ff <= config_ff;
      endcase
    end
  end

  // Sticky events: a new warning or out-of-range result; set wins over clear
  always_comb begin
    irq_set = 16'h0000;
    if (sample_valid && is_chan) begin
      irq_set[tc_reporter_pkg::STATUS_WARN_LSB + int'(chan_idx)] = band_warn && !band_oor;
      irq_set[tc_reporter_pkg::STATUS_OOR_LSB + int'(chan_idx)] = band_oor;
    end
    irq_clr = 16'h0000;
    if (wr_en && paddr == tc_reporter_pkg::IRQ_STS_OFS) begin
      irq_clr = pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_ff <= tc_reporter_pkg::IRQ_RST;
    end else begin
      irq_sts_ff <= (irq_sts_ff & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_sts_ff & irq_mask_ff);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_status_exclusive: assert property ((warn_ff & oor_ff) == 8'h00)
    else $error("warning and out-of-range both set");
  chk_over_saturate: assert property (sample_valid && is_chan && !band_mv && band_over
    |=> reading_ff[$past(chan_idx)] == tc_reporter_pkg::SAT_OVER_CODE)
    else $error("over range word not 7FFFh");
  chk_under_saturate: assert property (sample_valid && is_chan && !band_mv && band_under
    && !sample_open |=> reading_ff[$past(chan_idx)] == tc_reporter_pkg::SAT_UNDER_CODE)
    else $error("under range word not 8001h");
  chk_open_flags: assert property (sample_valid && is_chan && !band_mv && sample_open
    |=> oor_ff[$past(chan_idx)] && !warn_ff[$past(chan_idx)])
    else $error("open thermocouple flags wrong");
  chk_tc_ocd_forced: assert property (sample_valid && is_chan && !band_mv && sample_open
    && ocd_dis_ff[chan_idx] |=> oor_ff[$past(chan_idx)])
    else $error("thermocouple open detect was disabled");
  chk_mv_offset: assert property (sample_valid && is_chan && band_mv
    |=> reading_ff[$past(chan_idx)] == ($past(sample_value) ^ tc_reporter_pkg::MV_SIGN_FLIP))
    else $error("millivolt word not offset binary");
  chk_mv_full_oor: assert property (sample_valid && is_chan && band_mv && !ocd_dis_ff[chan_idx]
    && mv_word == tc_reporter_pkg::MV_FULL_CODE |=> oor_ff[$past(chan_idx)])
    else $error("millivolt full scale not out of range");
  chk_warn_band: assert property (sample_valid && is_chan && band_warn
    |=> warn_ff[$past(chan_idx)] && !oor_ff[$past(chan_idx)] && irq_sts_ff[$past(chan_idx)])
    else $error("warning band not reported");
  chk_cjc_tenth_c: assert property (sample_valid && is_cjc && config_ff == tc_reporter_pkg::CONFIG_RST
    |=> int_temp_ff == $past(sample_value))
    else $error("tenth degree C internal word wrong");
  chk_cjc_format: assert property (sample_valid && is_cjc |=> int_temp_ff == $past(enc_word))
    else $error("internal word not in channel format");
  chk_irq_level: assert property ((irq_set & irq_mask_ff) != 16'h0000
    |=> irq)
    else $error("masked-in event did not raise interrupt");

  cov_over_range: cover property (sample_valid && is_chan && band_over);
  cov_mv_full: cover property (sample_valid && is_chan && band_mv && band_oor);
  cov_cjc_update: cover property (sample_valid && is_cjc ##1 rd_setup);
  cov_irq_clear: cover property (irq ##1 !irq);
endmodule

//--- test/apb_host_model.sv
// Partner model: controller processor reaching the reporter over APB
`timescale 1ns/1ps
module apb_host_model (
  // Clock
  input wire logic pclk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // One transfer; the wait for pready is bounded, ok stays low if it runs out
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] data,
                      output logic [31:0] rdata, output logic err, output logic ok);
    int n;
    ok = 1'b0;
    err = 1'b0;
    rdata = 32'h0000_0000;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 64 && !ok; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        ok = 1'b1;
        rdata = prdata;
        err = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so a stale value never passes for a live one
    paddr <= ~addr;
    pwdata <= ~data;
  endtask
endmodule

//--- test/test_thermocouple_input_result_reporter.sv
// Testbench for the thermocouple result reporter
`timescale 1ns/1ps
module test_thermocouple_input_result_reporter;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sample_valid, sample_open;
  logic [3:0] sample_channel;
  logic [15:0] sample_value;
  int n_errors, checked;

  tc_result_reporter uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .sample_channel(sample_channel), .sample_value(sample_value),
    .sample_open(sample_open), .irq(irq));
  apb_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  task acc(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    logic ok;
    host.xfer(w, a, d, r, e, ok);
    if (ok !== 1'b1) begin
      n_errors++;
      $display("FAIL %0t bus wait ran out", $time);
      report_and_stop;
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    acc(1'b1, a, d, r, e);
    check({31'h0000_0000, e}, 32'h0000_0000, "write slave error");
  endtask

  task rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    acc(1'b0, a, 32'h0000_0000, r, e);
    check(r, exp, $sformatf("read %h", a));
    check({31'h0000_0000, e}, 32'h0000_0000, "read slave error");
  endtask

  // One sample, taken at the edge after it is driven
  task samp(input logic [3:0] ch, input logic [15:0] val, input logic open);
    @(posedge pclk);
    sample_valid <= 1'b1;
    sample_channel <= ch;
    sample_value <= val;
    sample_open <= open;
    @(posedge pclk);
    sample_valid <= 1'b0;
    sample_value <= ~val;
    sample_open <= 1'b0;
  endtask

  task reset_values;
    logic [31:0] r;
    logic e;
    rd(12'h028, 32'h0000_0002);
    rd(12'h020, 32'h0000_0000);
    rd(12'h024, 32'h0000_0000);
    rd(12'h01C, 32'h0000_0000);
    check({31'h0000_0000, irq}, 32'h0000_0000, "irq after reset");
    // Reading words are read-only
    wr(12'h000, 32'h0000_1234);
    rd(12'h000, 32'h0000_0000);
    // Misaligned and unmapped places answer with an error
    acc(1'b0, 12'h002, 32'h0000_0000, r, e);
    check({31'h0000_0000, e}, 32'h0000_0001, "misaligned read");
    acc(1'b0, 12'h03C, 32'h0000_0000, r, e);
    check(r, 32'h0000_0000, "unmapped data");
    acc(1'b1, 12'h040, 32'hFFFF_FFFF, r, e);
    check({31'h0000_0000, e}, 32'h0000_0001, "unmapped write");
  endtask

  // Type J band edges in tenths C
  task j_bands;
    samp(4'h0, 16'h1DB0, 1'b0);
    rd(12'h020, 32'h0000_0000);
    samp(4'h0, 16'h1DB1, 1'b0);
    rd(12'h000, 32'h0000_1DB1);
    rd(12'h020, 32'h0000_0001);
    samp(4'h0, 16'h1E6A, 1'b0);
    rd(12'h020, 32'h0000_0001);
    samp(4'h0, 16'h1E6B, 1'b0);
    rd(12'h000, 32'h0000_7FFF);
    rd(12'h020, 32'h0000_0100);
    samp(4'h0, 16'hF713, 1'b0);
    rd(12'h000, 32'h0000_F713);
    samp(4'h0, 16'hF712, 1'b0);
    rd(12'h000, 32'h0000_8001);
    samp(4'h0, 16'h1DB1, 1'b1);
    rd(12'h020, 32'h0000_0100);
    samp(4'h7, 16'h1DB1, 1'b0);
    rd(12'h020, 32'h0000_0180);
    samp(4'h7, 16'h0000, 1'b0);
  endtask

  task units;
    wr(12'h028, 32'h0000_0000);
    samp(4'h0, 16'h04D2, 1'b0);
    rd(12'h000, 32'h0000_007B);
    samp(4'h0, 16'hF830, 1'b0);
    rd(12'h000, 32'h0000_FF38);
    wr(12'h028, 32'h0000_0001);
    samp(4'h8, 16'h03E8, 1'b0);
    rd(12'h024, 32'h0000_00D4);
    wr(12'h028, 32'h0000_0003);
    samp(4'h8, 16'h03E8, 1'b0);
    rd(12'h024, 32'h0000_0848);
    // Type B at its normal top needs the unsigned word in tenths F
    wr(12'h02C, 32'h0000_0006);
    samp(4'h0, 16'h4718, 1'b0);
    rd(12'h000, 32'h0000_8138);
    wr(12'h028, 32'h0000_0002);
  endtask

  task millivolt;
    wr(12'h02C, 32'h0000_0070);
    samp(4'h1, 16'h8000, 1'b0);
    rd(12'h004, 32'h0000_0000);
    samp(4'h1, 16'h7FFF, 1'b0);
    rd(12'h004, 32'h0000_FFFF);
    rd(12'h020, 32'h0000_0200);
    wr(12'h030, 32'h0000_0002);
    samp(4'h1, 16'h7FFF, 1'b1);
    rd(12'h020, 32'h0000_0000);
    wr(12'h02C, 32'h0000_0080);
    wr(12'h030, 32'h0000_0000);
    samp(4'h1, 16'h0000, 1'b1);
    rd(12'h004, 32'h0000_8000);
    rd(12'h020, 32'h0000_0200);
    // A thermocouple channel ignores its disable bit
    wr(12'h02C, 32'h0000_0000);
    wr(12'h030, 32'h0000_0001);
    samp(4'h0, 16'h0000, 1'b1);
    rd(12'h020, 32'h0000_0300);
    wr(12'h030, 32'h0000_0000);
    samp(4'h1, 16'h0000, 1'b0);
  endtask

  // A write lands at the edge the task returns on, so irq is looked at once it has settled
  task chk_irq(input logic exp, input string what);
    @(negedge pclk);
    check({31'h0000_0000, irq}, {31'h0000_0000, exp}, what);
  endtask

  task irq_flow;
    wr(12'h034, 32'h0000_FFFF);
    wr(12'h038, 32'h0000_0001);
    samp(4'h0, 16'h1DB1, 1'b0);
    rd(12'h034, 32'h0000_0001);
    chk_irq(1'b1, "irq on warning");
    samp(4'h2, 16'h1E6B, 1'b0);
    rd(12'h034, 32'h0000_0401);
    wr(12'h038, 32'h0000_0000);
    chk_irq(1'b0, "irq masked");
    wr(12'h038, 32'h0000_0400);
    chk_irq(1'b1, "irq unmasked");
    wr(12'h034, 32'h0000_0400);
    rd(12'h034, 32'h0000_0001);
    chk_irq(1'b0, "irq cleared");
  endtask

  initial begin
    n_errors = 0;
    checked = 0;
    presetn = 1'b0;
    sample_valid = 1'b0;
    sample_channel = 4'h0;
    sample_value = 16'h0000;
    sample_open = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    reset_values;
    j_bands;
    units;
    millivolt;
    irq_flow;
    report_and_stop;
  end

  // Whole-run limit
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    $display("FAIL %0t run limit reached", $time);
    report_and_stop;
  end
endmodule
